// *** inc/wdnr_pkg.sv ***
package wdnr_pkg;

	// ------------------------------------------------------------------
	// Register map.
	// ------------------------------------------------------------------
	localparam logic [15:0] WDNR_ADDR_CONTROL = 16'h5040;
	localparam logic [15:0] WDNR_ADDR_STATUS = 16'h5041;
	localparam logic [15:0] WDNR_ADDR_IRQ_STATUS = 16'h5042;
	localparam logic [15:0] WDNR_ADDR_IRQ_CLEAR = 16'h5043;
	localparam logic [15:0] WDNR_ADDR_IRQ_ENABLE = 16'h5044;

	// ------------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------------
	localparam int WDNR_CTL_KEY_LSB = 0;
	localparam int WDNR_CTL_KEY_MSB = 3;
	localparam int WDNR_CTL_RESTART_BIT = 4;
	localparam int WDNR_ST_FLAG_BIT = 0;
	localparam int WDNR_ST_MODE_BIT = 1;
	localparam int WDNR_IRQ_NMI_BIT = 0;
	localparam int WDNR_IRQ_RST_BIT = 1;
	localparam int WDNR_IRQ_NUM = 2;

	// ------------------------------------------------------------------
	// Values after reset and codes.
	// ------------------------------------------------------------------
	localparam logic [3:0] WDNR_KEY_STOP = 4'hA;
	localparam logic [3:0] WDNR_KEY_RESET = 4'hA;
	localparam logic WDNR_MODE_NMI = 1'b0;
	localparam logic WDNR_MODE_RESET = 1'b1;
	localparam logic WDNR_MODE_RESET_VALUE = 1'b0;
	localparam logic WDNR_FLAG_RESET_VALUE = 1'b0;
	localparam logic [1:0] WDNR_IRQ_RESET_VALUE = 2'h0;
	localparam logic [7:0] WDNR_RDATA_RESET_VALUE = 8'h00;
	localparam logic [31:0] WDNR_CNT_RESET_VALUE = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Timing: default expiry period in core clock cycles.
	// ------------------------------------------------------------------
	localparam logic [31:0] WDNR_PERIOD_CYCLES_DEFAULT = 32'h0100_0000;

endpackage : wdnr_pkg

// *** verilog/wdnr_watchdog.sv ***
// Strobed register access was decided locally.
`timescale 1ns/1ns
module wdnr_watchdog #(
	parameter logic [31:0] PERIOD_CYCLES = wdnr_pkg::WDNR_PERIOD_CYCLES_DEFAULT
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_nmi,
	output logic o_sys_rst,
	output logic o_irq
);

	// ------------------------------------------------------------------
	// State of the block.
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] cnt;
		logic [3:0] run_stop_key;
		logic expiry_action_select;
		logic nmi_occurred_flag;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		logic [7:0] rdata;
		logic nmi;
		logic sys_rst;
	} wdnr_state_t;

	wdnr_state_t st_reg;
	wdnr_state_t st_next;

	logic wr_ctl;
	logic wr_st;
	logic wr_clr;
	logic wr_en;
	logic running;
	logic restart;
	logic expire;

	// ------------------------------------------------------------------
	// Decode of register writes.
	// ------------------------------------------------------------------

	// Writes are decoded on the full address so aliases cannot disturb the key.
	assign wr_ctl = i_wr && (i_addr == wdnr_pkg::WDNR_ADDR_CONTROL);
	assign wr_st = i_wr && (i_addr == wdnr_pkg::WDNR_ADDR_STATUS);
	assign wr_clr = i_wr && (i_addr == wdnr_pkg::WDNR_ADDR_IRQ_CLEAR);
	assign wr_en = i_wr && (i_addr == wdnr_pkg::WDNR_ADDR_IRQ_ENABLE);

	// The counter runs for every key pattern except the stop pattern.
	assign running = (st_reg.run_stop_key != wdnr_pkg::WDNR_KEY_STOP);
	assign restart = wr_ctl && i_wdata[wdnr_pkg::WDNR_CTL_RESTART_BIT];
	// A restart in the expiry cycle wins, so software that kicks in time never sees a bite.
	assign expire = running && !restart && (st_reg.cnt == PERIOD_CYCLES - 32'h0000_0001);

	// ------------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------------

	// All state is computed here and registered in one process below.
	always_comb begin
		st_next = st_reg;
		st_next.nmi = 1'b0;
		st_next.sys_rst = 1'b0;

		// Counter: cleared by restart or expiry, held while stopped.
		if (restart || expire) begin
			st_next.cnt = wdnr_pkg::WDNR_CNT_RESET_VALUE;
		end else if (running) begin
			st_next.cnt = st_reg.cnt + 32'h0000_0001;
		end

		// Control writes take only the key field; the restart bit is not stored.
		if (wr_ctl) begin
			st_next.run_stop_key = i_wdata[wdnr_pkg::WDNR_CTL_KEY_MSB:wdnr_pkg::WDNR_CTL_KEY_LSB];
		end

		// Status writes take only the mode bit; the flag is read-only.
		if (wr_st) begin
			st_next.expiry_action_select = i_wdata[wdnr_pkg::WDNR_ST_MODE_BIT];
		end

		// The NMI flag is cleared by a restart; a restart also blocks expiry, so no new NMI comes in that cycle.
		if (restart) begin
			st_next.nmi_occurred_flag = 1'b0;
		end

		// Expiry action follows the mode bit.
		if (expire) begin
			if (st_reg.expiry_action_select == wdnr_pkg::WDNR_MODE_RESET) begin
				st_next.sys_rst = 1'b1;
			end else begin
				st_next.nmi = 1'b1;
				st_next.nmi_occurred_flag = 1'b1;
			end
		end

		// Interrupt enable register.
		if (wr_en) begin
			st_next.irq_enable = i_wdata[wdnr_pkg::WDNR_IRQ_NUM-1:0];
		end

		// Sticky status: write-one clears, a new event in the same cycle wins.
		for (int i = 0; i < wdnr_pkg::WDNR_IRQ_NUM; i++) begin
			if (wr_clr && i_wdata[i]) begin
				st_next.irq_status[i] = 1'b0;
			end
		end
		if (expire && st_reg.expiry_action_select == wdnr_pkg::WDNR_MODE_NMI) begin
			st_next.irq_status[wdnr_pkg::WDNR_IRQ_NMI_BIT] = 1'b1;
		end
		if (expire && st_reg.expiry_action_select == wdnr_pkg::WDNR_MODE_RESET) begin
			st_next.irq_status[wdnr_pkg::WDNR_IRQ_RST_BIT] = 1'b1;
		end

		// Read data for the cycle after the strobe; unused bits and unmapped reads give 0.
		st_next.rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				wdnr_pkg::WDNR_ADDR_CONTROL: begin
					st_next.rdata = {4'h0, st_reg.run_stop_key};
				end
				wdnr_pkg::WDNR_ADDR_STATUS: begin
					st_next.rdata = {6'h00, st_reg.expiry_action_select,
						st_reg.nmi_occurred_flag};
				end
				wdnr_pkg::WDNR_ADDR_IRQ_STATUS: begin
					st_next.rdata = {6'h00, st_reg.irq_status};
				end
				wdnr_pkg::WDNR_ADDR_IRQ_ENABLE: begin
					st_next.rdata = {6'h00, st_reg.irq_enable};
				end
				default: begin
					st_next.rdata = 8'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register.
	// ------------------------------------------------------------------

	// The watchdog comes out of reset stopped, so boot code may arm it late.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg.cnt <= wdnr_pkg::WDNR_CNT_RESET_VALUE;
			st_reg.run_stop_key <= wdnr_pkg::WDNR_KEY_RESET;
			st_reg.expiry_action_select <= wdnr_pkg::WDNR_MODE_RESET_VALUE;
			st_reg.nmi_occurred_flag <= wdnr_pkg::WDNR_FLAG_RESET_VALUE;
			st_reg.irq_status <= wdnr_pkg::WDNR_IRQ_RESET_VALUE;
			st_reg.irq_enable <= wdnr_pkg::WDNR_IRQ_RESET_VALUE;
			st_reg.rdata <= wdnr_pkg::WDNR_RDATA_RESET_VALUE;
			st_reg.nmi <= 1'b0;
			st_reg.sys_rst <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------------

	// Expiry pulses and read data come straight from flip-flops.
	assign o_rdata = st_reg.rdata;
	assign o_nmi = st_reg.nmi;
	assign o_sys_rst = st_reg.sys_rst;
	assign o_irq = |(st_reg.irq_status & st_reg.irq_enable);

endmodule : wdnr_watchdog

// *** tb/wdnr_assertions.sv ***
`timescale 1ns/1ns
module wdnr_assertions (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_nmi,
	input wire logic o_sys_rst,
	input wire logic o_irq
);
	// ----------------------------------------
	// Read data and expiry request checks.
	// ----------------------------------------
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// Read data must not linger, or a stale byte could be taken for a fresh one.
	rd_idle_a:
	assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
	ctl_read_a:
	assert property ($past(i_rd) && $past(i_addr) == 16'h5040 |-> o_rdata[7:4] == 4'h0)
		else $error("control upper bits set");
	st_read_a:
	assert property ($past(i_rd) && $past(i_addr) == 16'h5041 |-> o_rdata[7:2] == 6'h00)
		else $error("status upper bits set");
	stop_holds_a:
	assert property (i_wr && i_addr == 16'h5040 && i_wdata[3:0] == 4'hA ##1 !i_wr [*8]
		|=> !o_nmi && !o_sys_rst) else $error("expiry while stopped");
	restart_a:
	assert property (i_wr && i_addr == 16'h5040 && i_wdata[4] |=> (!o_nmi && !o_sys_rst) [*3])
		else $error("expiry after restart");
	one_action_a:
	assert property (!(o_nmi && o_sys_rst)) else $error("both expiry actions");
	nmi_pulse_a:
	assert property ($rose(o_nmi) |=> !o_nmi) else $error("nmi pulse too long");
endmodule : wdnr_assertions

// *** tb/wdnr_core_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Core side: counts the expiry requests.
// ----------------------------------------
module wdnr_core_model (
	input wire logic i_core_clk,
	input wire logic i_nmi,
	input wire logic i_sys_rst,
	output int o_nmi_cnt = 0,
	output int o_rst_cnt = 0
);
	// Requests are one-cycle pulses, so each high sample is one request.
	always @(posedge i_core_clk) begin
		if (i_nmi) o_nmi_cnt <= o_nmi_cnt + 1;
		if (i_sys_rst) o_rst_cnt <= o_rst_cnt + 1;
	end
endmodule : wdnr_core_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
	logic clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, irq, nmi, srst;
	logic [15:0] a = 16'h0000;
	logic [7:0] d = 8'h00, rdat, r;
	logic [7:0] q[$];
	int n_fail = 0, compares = 0, cyc = 0, nc, rc;
	always #4 clk = ~clk;
	wdnr_watchdog #(.PERIOD_CYCLES(32'h0000_0008)) dut_u (.i_core_clk(clk), .i_rst(rst),
		.i_addr(a), .i_wdata(d), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_nmi(nmi),
		.o_sys_rst(srst), .o_irq(irq));
	wdnr_core_model core_u (.i_core_clk(clk), .i_nmi(nmi), .i_sys_rst(srst),
		.o_nmi_cnt(nc), .o_rst_cnt(rc));
	task chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task wrt(input logic [15:0] ad, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		a <= ad;
		d <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrt
	task rdx(input logic [15:0] ad, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		a <= ad;
		q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rdx
	task report_and_stop;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------
	// Monitor: read data stands only in the cycle after the strobe.
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			report_and_stop();
		end
		if (rd_d) chk(rdat, q.pop_front());
		rd_d <= rd;
	end
	// Each run phase restarts the count first so the expiry moment is known.
	initial begin
		void'($urandom(83047));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdx(16'h5040, 8'h0A);
		rdx(16'h5041, 8'h00);
		rdx(16'h5045, 8'h00);
		for (int i = 0; i < 6; i++) begin
			r = 8'($urandom()) | 8'h10;
			wrt(16'h5040, r);
			rdx(16'h5040, {4'h0, r[3:0]});
			wrt(16'h5040, 8'h1A);
			wrt(16'h5041, r);
			rdx(16'h5041, {6'h00, r[1], 1'b0});
		end
		wrt(16'h5044, 8'h03);
		wrt(16'h5041, 8'h00);
		wrt(16'h5040, 8'h10);
		repeat (10) @(posedge clk);
		wrt(16'h5040, 8'h0A);
		chk(nc[7:0], 8'h01);
		rdx(16'h5041, 8'h01);
		rdx(16'h5042, 8'h01);
		wrt(16'h5044, 8'h00);
		@(negedge clk) chk({7'h00, irq}, 8'h00);
		wrt(16'h5044, 8'h03);
		@(negedge clk) chk({7'h00, irq}, 8'h01);
		wrt(16'h5043, 8'h01);
		@(negedge clk) chk({7'h00, irq}, 8'h00);
		wrt(16'h5040, 8'h10);
		rdx(16'h5041, 8'h00);
		repeat (5) wrt(16'h5040, 8'h10);
		wrt(16'h5040, 8'h0A);
		chk(nc[7:0], 8'h01);
		wrt(16'h5041, 8'h02);
		wrt(16'h5040, 8'h10);
		repeat (10) @(posedge clk);
		wrt(16'h5040, 8'h0A);
		chk(rc[7:0], 8'h01);
		rdx(16'h5041, 8'h02);
		repeat (12) @(posedge clk);
		report_and_stop();
	end
endmodule : tb_top
bind wdnr_watchdog wdnr_assertions chk_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_nmi(o_nmi), .o_sys_rst(o_sys_rst), .o_irq(o_irq));
